// ### logic/mss_pkg.sv
// Purpose: shared types and constants for the motor start sequencer
// Assumes: 200 MHz clk, durations given in microseconds by the user
// Notes: bridge command codes and state codes are shared with the bench
package mss_pkg;
  localparam int CLK_MHZ = 200;
  localparam int SPEED_W = 16;
  localparam int TIME_W = 16;
  localparam int CYC_W = 32;
  localparam int CYCLES_PER_US = CLK_MHZ;
  localparam int INIT_CYCLES = 16;

  // bridge drive commands seen by the power stage
  typedef enum logic [2:0] {
    MSS_BR_OFF = 3'h0,
    MSS_BR_BRAKE_LOW = 3'h1,
    MSS_BR_BRAKE_HIGH = 3'h2,
    MSS_BR_STARTUP = 3'h3,
    MSS_BR_OPEN_LOOP = 3'h4,
    MSS_BR_CLOSED_LOOP = 3'h5,
    MSS_BR_REV_CLOSED = 3'h6,
    MSS_BR_REV_OPEN = 3'h7
  } mss_bridge_type;

  typedef enum logic [4:0] {
    MSS_ST_INIT = 5'h00,
    MSS_ST_IDLE = 5'h01,
    MSS_ST_ISD_CHECK = 5'h02,
    MSS_ST_ISD_RUN = 5'h03,
    MSS_ST_DIR_EVAL = 5'h04,
    MSS_ST_RESYNC_CHECK = 5'h05,
    MSS_ST_RESYNC_SPEED = 5'h06,
    MSS_ST_REV_CHECK = 5'h07,
    MSS_ST_REV_CLOSED = 5'h08,
    MSS_ST_REV_OPEN = 5'h09,
    MSS_ST_COAST_CHECK = 5'h0A,
    MSS_ST_COAST = 5'h0B,
    MSS_ST_BRAKE_CHECK = 5'h0C,
    MSS_ST_BRAKE = 5'h0D,
    MSS_ST_STARTUP = 5'h0E,
    MSS_ST_OPEN_LOOP = 5'h0F,
    MSS_ST_CLOSED_LOOP = 5'h10
  } mss_state_type;

  typedef enum logic [1:0] {
    MSS_START_ALIGN = 2'h0,
    MSS_START_DOUBLE_ALIGN = 2'h1,
    MSS_START_IPD = 2'h2,
    MSS_START_SLOW_CYCLE = 2'h3
  } mss_start_type;

  // configuration loaded from non-volatile storage
  typedef struct packed {
    logic deviceOperatingSelect;
    logic initialSpinDetectEnable;
    logic resyncEnable;
    logic counterRotationDriveEnable;
    logic coastEnable;
    logic brakeEnable;
    logic brakingTypeSelect;
    logic brakingSideSelect;
    logic counterRotationParamSelect;
    logic reversalPathSelect;
    mss_start_type standstillStartMethod;
    logic [SPEED_W-1:0] stationaryBemfThreshold;
    logic [SPEED_W-1:0] forwardResyncSpeedThreshold;
    logic [SPEED_W-1:0] openClosedHandoffSpeed;
    logic [SPEED_W-1:0] revHandoffSpeed;
    logic [SPEED_W-1:0] brakingCurrentThreshold;
    logic [TIME_W-1:0] coastDuration;
    logic [TIME_W-1:0] brakingDuration;
    logic [TIME_W-1:0] brakingCurrentPersistTime;
  } mss_cfg_type;

  // result of initial spin detection
  typedef struct packed {
    logic [SPEED_W-1:0] bemf;
    logic [SPEED_W-1:0] speed;
    logic [SPEED_W-1:0] angle;
    logic reverse;
  } mss_isd_type;

  localparam logic BRAKE_TYPE_TIME = 1'b0;
  localparam logic BRAKE_TYPE_CURRENT = 1'b1;
  localparam logic BRAKE_SIDE_LOW = 1'b0;
  localparam logic PATH_ISD = 1'b0;
  localparam logic MODE_STANDBY = 1'b0;
endpackage : mss_pkg

// ### logic/mss_timer.sv
// Purpose: microsecond down-counter used for coast and brake timing
// Assumes: start pulse loads a duration in microseconds
// Notes: done pulses once; zero duration ends after one cycle
`timescale 1ns/1ps
`default_nettype none
module mss_timer
  import mss_pkg::*;
#(
  parameter int CYC_PER_US = mss_pkg::CYCLES_PER_US
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic start,
  input wire logic abort,
  input wire logic [mss_pkg::TIME_W-1:0] durationUs,
  output logic done
);
  import mss_pkg::*;

  typedef struct packed {
    logic running;
    logic [CYC_W-1:0] count;
    logic done;
  } mss_timer_state_type;

  mss_timer_state_type s_reg;
  mss_timer_state_type s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start) begin
      s_next.running = 1'b1;
      s_next.count = CYC_W'(durationUs) * CYC_W'(CYC_PER_US);
    end else if (abort) begin
      s_next.running = 1'b0;
    end else if (s_reg.running) begin
      if (s_reg.count <= CYC_W'(1)) begin
        s_next.running = 1'b0;
        s_next.done = 1'b1;
      end else begin
        s_next.count = s_reg.count - CYC_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
endmodule : mss_timer
`default_nettype wire

// ### logic/mss_persist.sv
// Purpose: checks that phase current stays below a threshold for a persist time
// Assumes: current magnitude sampled on clk
// Notes: any sample at or above threshold restarts the window
`timescale 1ns/1ps
`default_nettype none
module mss_persist
  import mss_pkg::*;
#(
  parameter int CYC_PER_US = mss_pkg::CYCLES_PER_US
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic enable,
  input wire logic [mss_pkg::SPEED_W-1:0] current,
  input wire logic [mss_pkg::SPEED_W-1:0] threshold,
  input wire logic [mss_pkg::TIME_W-1:0] persistUs,
  output logic settled
);
  import mss_pkg::*;

  typedef struct packed {
    logic [CYC_W-1:0] count;
    logic settled;
  } mss_persist_state_type;

  mss_persist_state_type s_reg;
  mss_persist_state_type s_next;
  logic [CYC_W-1:0] target;

  assign target = CYC_W'(persistUs) * CYC_W'(CYC_PER_US);

  always_comb begin
    s_next = s_reg;
    if (!enable || current >= threshold) begin
      s_next.count = '0;
      s_next.settled = 1'b0;
    end else if (s_reg.count >= target) begin
      s_next.settled = 1'b1;
    end else begin
      s_next.count = s_reg.count + CYC_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign settled = s_reg.settled;
endmodule : mss_persist
`default_nettype wire

// ### logic/mss_sequencer.sv
// Purpose: motor start sequencer from power-on to closed loop
// Assumes: speed, bemf and current inputs come from same-clock logic
// Notes: wake pin is asynchronous and is synchronised here
// Function
// - at power-up set up peripherals and load parameters before driving
// - idle holds speed target zero; sleep or standby from mode and wake pin
// - leave idle for spin detect check once speed reference is above zero
// - direction change goes to spin detect check or reverse speed check
// - spin detect enabled runs bemf comparison, else braking check
// - spin detection gives speed, position and direction from phase voltages
// - bemf below stationary threshold means stopped, go to braking check
// - forward spin goes to resync check, reverse to counter-rotation check
// - resync enabled compares forward speed, else coast check
// - fast forward spin enters closed loop seeded, slow enters open loop
// - counter-rotation enabled checks reverse speed, else coast check
// - above handoff decelerate closed loop, at or below switch to open loop
// - reverse drive crosses zero in open loop then enters closed loop
// - coast enabled runs coast routine, else braking check
// - coast turns off all six bridge transistors for coast duration
// - brake enabled runs brake routine, else motor start-up
// - brake is time based or current-below-threshold for persist time
// - current based brake also ends at braking duration timeout
// - time brake uses selected side; current brake always low side
// - closed loop drives with sensorless field-oriented control
// - reverse drive uses forward or dedicated reverse parameter set
// - param select 1 uses reverse handoff, accel, current limit set
// - start method code picks align, double align, position detect, slow cycle
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer
  import mss_pkg::*;
#(
  parameter int CYC_PER_US = mss_pkg::CYCLES_PER_US,
  parameter int INIT_LEN = mss_pkg::INIT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire mss_pkg::mss_cfg_type cfgNvm,
  input wire logic cfgValid,
  input wire logic wakePin,
  input wire logic [mss_pkg::SPEED_W-1:0] speedRef,
  input wire logic dirChangeCmd,
  input wire logic isdDone,
  input wire mss_pkg::mss_isd_type isdResult,
  input wire logic [mss_pkg::SPEED_W-1:0] motorSpeed,
  input wire logic [mss_pkg::SPEED_W-1:0] phaseCurrent,
  input wire logic startupDone,
  input wire logic zeroCrossed,
  output logic periphInit,
  output logic nvmLoad,
  output logic ready,
  output logic sleepMode,
  output logic standbyMode,
  output logic [mss_pkg::SPEED_W-1:0] speedTarget,
  output logic isdStart,
  output mss_pkg::mss_bridge_type bridgeCmd,
  output mss_pkg::mss_start_type startMethod,
  output logic useReverseParams,
  output logic seedValid,
  output logic [mss_pkg::SPEED_W-1:0] seedSpeed,
  output logic [mss_pkg::SPEED_W-1:0] seedAngle,
  output mss_pkg::mss_state_type stateOut
);
  import mss_pkg::*;

  typedef struct packed {
    mss_state_type state;
    mss_cfg_type cfg;
    logic [7:0] initCnt;
    logic wakeMeta;
    logic wakeSync;
    logic isdStart;
    logic seedValid;
    logic [SPEED_W-1:0] seedSpeed;
    logic [SPEED_W-1:0] seedAngle;
    logic revCrossed;
    logic timerStart;
    logic isdReverse;
  } mss_seq_state_type;

  mss_seq_state_type s_reg;
  mss_seq_state_type s_next;
  logic timerDone;
  logic currentSettled;
  logic brakeActive;
  logic [TIME_W-1:0] timerDuration;
  logic [SPEED_W-1:0] handoffLevel;

  // one timer serves coast and brake since they never overlap
  assign timerDuration = (s_reg.state == MSS_ST_COAST) ?
      s_reg.cfg.coastDuration : s_reg.cfg.brakingDuration;
  assign brakeActive = (s_reg.state == MSS_ST_BRAKE);
  assign handoffLevel = s_reg.cfg.counterRotationParamSelect ?
      s_reg.cfg.revHandoffSpeed : s_reg.cfg.openClosedHandoffSpeed;

  mss_timer #(.CYC_PER_US(CYC_PER_US)) u_timer (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .start(s_reg.timerStart),
    .abort(!brakeActive && s_reg.state != MSS_ST_COAST), // no stale done after an exit
    .durationUs(timerDuration),
    .done(timerDone)
  );

  mss_persist #(.CYC_PER_US(CYC_PER_US)) u_persist (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .enable(brakeActive && s_reg.cfg.brakingTypeSelect == BRAKE_TYPE_CURRENT),
    .current(phaseCurrent),
    .threshold(s_reg.cfg.brakingCurrentThreshold),
    .persistUs(s_reg.cfg.brakingCurrentPersistTime),
    .settled(currentSettled)
  );

  always_comb begin
    s_next = s_reg;
    s_next.wakeMeta = wakePin;
    s_next.wakeSync = s_reg.wakeMeta;
    s_next.isdStart = 1'b0;
    s_next.timerStart = 1'b0;
    unique case (s_reg.state)
      MSS_ST_INIT: begin
        if (s_reg.initCnt < 8'(INIT_LEN)) begin
          s_next.initCnt = s_reg.initCnt + 8'h01;
        end else if (cfgValid) begin
          s_next.cfg = cfgNvm;
          s_next.state = MSS_ST_IDLE;
        end
      end
      MSS_ST_IDLE: begin
        s_next.seedValid = 1'b0;
        if (speedRef != '0) begin
          s_next.state = MSS_ST_ISD_CHECK;
        end
      end
      MSS_ST_ISD_CHECK: begin
        if (s_reg.cfg.initialSpinDetectEnable) begin
          s_next.state = MSS_ST_ISD_RUN;
          s_next.isdStart = 1'b1;
        end else begin
          s_next.state = MSS_ST_BRAKE_CHECK;
        end
      end
      MSS_ST_ISD_RUN: begin
        if (isdDone) begin
          s_next.seedSpeed = isdResult.speed;
          s_next.seedAngle = isdResult.angle;
          s_next.isdReverse = isdResult.reverse;
          if (isdResult.bemf < s_reg.cfg.stationaryBemfThreshold) begin
            s_next.state = MSS_ST_BRAKE_CHECK;
          end else begin
            s_next.state = MSS_ST_DIR_EVAL;
          end
        end
      end
      MSS_ST_DIR_EVAL: begin
        // spin result only holds with its done pulse, so use the latched copy
        s_next.state = s_reg.isdReverse ? MSS_ST_REV_CHECK : MSS_ST_RESYNC_CHECK;
      end
      MSS_ST_RESYNC_CHECK: begin
        s_next.state = s_reg.cfg.resyncEnable ? MSS_ST_RESYNC_SPEED : MSS_ST_COAST_CHECK;
      end
      MSS_ST_RESYNC_SPEED: begin
        if (s_reg.seedSpeed > s_reg.cfg.forwardResyncSpeedThreshold) begin
          s_next.seedValid = 1'b1;
          s_next.state = MSS_ST_CLOSED_LOOP;
        end else begin
          s_next.state = MSS_ST_OPEN_LOOP;
        end
      end
      MSS_ST_REV_CHECK: begin
        s_next.revCrossed = 1'b0;
        s_next.state = s_reg.cfg.counterRotationDriveEnable ?
            MSS_ST_REV_CLOSED : MSS_ST_COAST_CHECK;
      end
      MSS_ST_REV_CLOSED: begin
        if (motorSpeed <= handoffLevel) begin
          s_next.state = MSS_ST_REV_OPEN;
        end
      end
      MSS_ST_REV_OPEN: begin
        if (zeroCrossed) begin
          s_next.revCrossed = 1'b1;
        end
        if (s_reg.revCrossed && motorSpeed > handoffLevel) begin
          s_next.state = MSS_ST_CLOSED_LOOP;
        end
      end
      MSS_ST_COAST_CHECK: begin
        if (s_reg.cfg.coastEnable) begin
          s_next.timerStart = 1'b1;
          s_next.state = MSS_ST_COAST;
        end else begin
          s_next.state = MSS_ST_BRAKE_CHECK;
        end
      end
      MSS_ST_COAST: begin
        if (timerDone) begin
          s_next.state = MSS_ST_BRAKE_CHECK;
        end
      end
      MSS_ST_BRAKE_CHECK: begin
        if (s_reg.cfg.brakeEnable) begin
          s_next.timerStart = 1'b1;
          s_next.state = MSS_ST_BRAKE;
        end else begin
          s_next.state = MSS_ST_STARTUP;
        end
      end
      MSS_ST_BRAKE: begin
        // timeout applies to both brake types
        if (timerDone) begin
          s_next.state = MSS_ST_STARTUP;
        end else if (s_reg.cfg.brakingTypeSelect == BRAKE_TYPE_CURRENT && currentSettled) begin
          s_next.state = MSS_ST_STARTUP;
        end
      end
      MSS_ST_STARTUP: begin
        if (startupDone) begin
          s_next.state = MSS_ST_OPEN_LOOP;
        end
      end
      MSS_ST_OPEN_LOOP: begin
        if (motorSpeed > s_reg.cfg.openClosedHandoffSpeed) begin
          s_next.state = MSS_ST_CLOSED_LOOP;
        end
      end
      MSS_ST_CLOSED_LOOP: begin
        s_next.state = MSS_ST_CLOSED_LOOP;
      end
      default: begin
        s_next.state = MSS_ST_INIT;
      end
    endcase
    // drop back to idle when the reference is withdrawn
    if (s_reg.state != MSS_ST_INIT && s_reg.state != MSS_ST_IDLE && speedRef == '0) begin
      s_next.state = MSS_ST_IDLE;
    end else if (s_reg.state != MSS_ST_INIT && s_reg.state != MSS_ST_IDLE && dirChangeCmd) begin
      s_next.seedValid = 1'b0;
      s_next.revCrossed = 1'b0;
      s_next.state = (s_reg.cfg.reversalPathSelect == PATH_ISD) ?
          MSS_ST_ISD_CHECK : MSS_ST_REV_CLOSED;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // bridge command from state
  always_comb begin
    unique case (s_reg.state)
      MSS_ST_BRAKE: begin
        if (s_reg.cfg.brakingTypeSelect == BRAKE_TYPE_CURRENT) begin
          bridgeCmd = MSS_BR_BRAKE_LOW;
        end else begin
          bridgeCmd = (s_reg.cfg.brakingSideSelect == BRAKE_SIDE_LOW) ?
              MSS_BR_BRAKE_LOW : MSS_BR_BRAKE_HIGH;
        end
      end
      MSS_ST_STARTUP: bridgeCmd = MSS_BR_STARTUP;
      MSS_ST_OPEN_LOOP: bridgeCmd = MSS_BR_OPEN_LOOP;
      MSS_ST_CLOSED_LOOP: bridgeCmd = MSS_BR_CLOSED_LOOP;
      MSS_ST_REV_CLOSED: bridgeCmd = MSS_BR_REV_CLOSED;
      MSS_ST_REV_OPEN: bridgeCmd = MSS_BR_REV_OPEN;
      default: bridgeCmd = MSS_BR_OFF;
    endcase
  end

  assign periphInit = (s_reg.state == MSS_ST_INIT) && (s_reg.initCnt < 8'(INIT_LEN));
  assign nvmLoad = (s_reg.state == MSS_ST_INIT) && (s_reg.initCnt >= 8'(INIT_LEN));
  assign ready = (s_reg.state != MSS_ST_INIT);
  assign sleepMode = (s_reg.state == MSS_ST_IDLE) &&
      (s_reg.cfg.deviceOperatingSelect != MODE_STANDBY) && !s_reg.wakeSync;
  assign standbyMode = (s_reg.state == MSS_ST_IDLE) && !sleepMode;
  assign speedTarget = (s_reg.state == MSS_ST_IDLE || s_reg.state == MSS_ST_INIT) ?
      '0 : speedRef;
  assign isdStart = s_reg.isdStart;
  assign startMethod = s_reg.cfg.standstillStartMethod;
  assign useReverseParams = s_reg.cfg.counterRotationParamSelect &&
      (s_reg.state == MSS_ST_REV_CLOSED || s_reg.state == MSS_ST_REV_OPEN);
  assign seedValid = s_reg.seedValid;
  assign seedSpeed = s_reg.seedSpeed;
  assign seedAngle = s_reg.seedAngle;
  assign stateOut = s_reg.state;

  a_idle_leave: assert property (@(posedge clk) disable iff (!nrst)
      (ce && s_reg.state == MSS_ST_IDLE && speedRef != '0) |=> s_reg.state == MSS_ST_ISD_CHECK)
    else $error("idle did not leave on speed ref");
  a_idle_target: assert property (@(posedge clk) disable iff (!nrst)
      s_reg.state == MSS_ST_IDLE |-> speedTarget == '0)
    else $error("speed target nonzero in idle");
  a_coast_off: assert property (@(posedge clk) disable iff (!nrst)
      s_reg.state == MSS_ST_COAST |-> bridgeCmd == MSS_BR_OFF)
    else $error("bridge driven during coast");
  a_coast_next: assert property (@(posedge clk) disable iff (!nrst)
      (ce && s_reg.state == MSS_ST_COAST && timerDone && speedRef != '0 && !dirChangeCmd)
      |=> s_reg.state == MSS_ST_BRAKE_CHECK)
    else $error("coast did not go to brake check");
  a_brake_low: assert property (@(posedge clk) disable iff (!nrst)
      (brakeActive && s_reg.cfg.brakingTypeSelect == BRAKE_TYPE_CURRENT)
      |-> bridgeCmd == MSS_BR_BRAKE_LOW)
    else $error("current brake not on low side");
  a_isd_skip: assert property (@(posedge clk) disable iff (!nrst)
      (ce && s_reg.state == MSS_ST_ISD_CHECK && !s_reg.cfg.initialSpinDetectEnable
      && speedRef != '0 && !dirChangeCmd) |=> s_reg.state == MSS_ST_BRAKE_CHECK)
    else $error("spin detect bypass wrong");
  a_brake_skip: assert property (@(posedge clk) disable iff (!nrst)
      (ce && s_reg.state == MSS_ST_BRAKE_CHECK && !s_reg.cfg.brakeEnable
      && speedRef != '0 && !dirChangeCmd) |=> s_reg.state == MSS_ST_STARTUP)
    else $error("brake bypass wrong");
  a_brake_timeout: assert property (@(posedge clk) disable iff (!nrst)
      (ce && brakeActive && timerDone && speedRef != '0 && !dirChangeCmd)
      |=> s_reg.state == MSS_ST_STARTUP)
    else $error("brake timeout ignored");
  a_dir_path: assert property (@(posedge clk) disable iff (!nrst)
      (ce && ready && s_reg.state != MSS_ST_IDLE && speedRef != '0 && dirChangeCmd
      && s_reg.cfg.reversalPathSelect != PATH_ISD) |=> s_reg.state == MSS_ST_REV_CLOSED)
    else $error("direction change path wrong");
endmodule : mss_sequencer
`default_nettype wire

// ### verification/mss_motor_model.sv
// Purpose: behavioural motor and spin-detect front end for the start sequencer
// Assumes: speed moves one unit per open-loop or reverse drive clock, current bleeds one unit per brake clock
// Notes: spin result is inverted outside its valid pulse so stale values never match
`timescale 1ns/1ps
`default_nettype none
module mss_motor_model
  import mss_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic isdStart,
  input wire mss_pkg::mss_bridge_type bridgeCmd,
  input wire mss_pkg::mss_isd_type isdPlan,
  input wire logic [15:0] speedInit,
  input wire logic [15:0] curInit,
  output logic isdDone,
  output mss_pkg::mss_isd_type isdResult,
  output logic [15:0] motorSpeed,
  output logic [15:0] phaseCurrent,
  output logic startupDone,
  output logic zeroCrossed
);
  logic [1:0] isdCnt;
  logic [2:0] stCnt;
  logic crossed;
  assign isdResult = isdDone ? isdPlan : ~isdPlan;
  assign startupDone = (stCnt == 3'h4);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      isdCnt <= 2'h0;
      isdDone <= 1'b0;
      stCnt <= 3'h0;
      crossed <= 1'b0;
      zeroCrossed <= 1'b0;
      motorSpeed <= 16'h0;
      phaseCurrent <= 16'h0;
    end else begin
      isdDone <= (isdCnt == 2'h1);
      zeroCrossed <= 1'b0;
      stCnt <= (bridgeCmd == MSS_BR_STARTUP) ? stCnt + 3'h1 : 3'h0;
      // brake bleeds current slowly, so a late threshold hit is visible
      if (bridgeCmd == MSS_BR_BRAKE_LOW || bridgeCmd == MSS_BR_BRAKE_HIGH) begin
        phaseCurrent <= (phaseCurrent != 16'h0) ? phaseCurrent - 16'h1 : 16'h0;
      end else begin
        phaseCurrent <= curInit;
      end
      case (bridgeCmd)
        MSS_BR_OPEN_LOOP: motorSpeed <= motorSpeed + 16'h1;
        MSS_BR_REV_CLOSED: motorSpeed <= motorSpeed - 16'h1;
        MSS_BR_REV_OPEN: begin
          if (!crossed && motorSpeed == 16'h0) begin
            crossed <= 1'b1;
            zeroCrossed <= 1'b1;
          end else begin
            motorSpeed <= crossed ? motorSpeed + 16'h1 : motorSpeed - 16'h1;
          end
        end
        default: ;
      endcase
      if (isdStart) begin
        isdCnt <= 2'h3;
        motorSpeed <= speedInit;
        crossed <= 1'b0;
      end else if (isdCnt != 2'h0) begin
        isdCnt <= isdCnt - 2'h1;
      end
    end
  end
endmodule : mss_motor_model
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: self-checking bench for the motor start sequencer
// Assumes: timers shortened to one cycle per microsecond, init shortened to 8
// Notes: configuration is captured once, so every scenario reboots the block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mss_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic cfgValid = 1'b0;
  logic wakePin = 1'b0;
  logic dirChangeCmd = 1'b0;
  logic [15:0] speedRef = 16'h0;
  logic [15:0] speedInit = 16'h0;
  logic [15:0] curInit = 16'h0;
  mss_cfg_type cfg = '0;
  mss_isd_type isdPlan = '0;
  mss_isd_type isdResult;
  logic isdDone, isdStart, startupDone, zeroCrossed, periphInit, nvmLoad, ready;
  logic sleepMode, standbyMode, useReverseParams, seedValid;
  logic [15:0] motorSpeed, phaseCurrent, speedTarget, seedSpeed, seedAngle;
  mss_bridge_type bridgeCmd;
  mss_start_type startMethod;
  mss_state_type stateOut;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  mss_sequencer #(.CYC_PER_US(1), .INIT_LEN(8)) u_dut (
    .clk(clk), .nrst(nrst), .ce(ce), .cfgNvm(cfg), .cfgValid(cfgValid), .wakePin(wakePin),
    .speedRef(speedRef), .dirChangeCmd(dirChangeCmd), .isdDone(isdDone),
    .isdResult(isdResult), .motorSpeed(motorSpeed), .phaseCurrent(phaseCurrent),
    .startupDone(startupDone), .zeroCrossed(zeroCrossed), .periphInit(periphInit),
    .nvmLoad(nvmLoad), .ready(ready), .sleepMode(sleepMode), .standbyMode(standbyMode),
    .speedTarget(speedTarget), .isdStart(isdStart), .bridgeCmd(bridgeCmd),
    .startMethod(startMethod), .useReverseParams(useReverseParams), .seedValid(seedValid),
    .seedSpeed(seedSpeed), .seedAngle(seedAngle), .stateOut(stateOut));
  mss_motor_model u_motor (
    .clk(clk), .nrst(nrst), .isdStart(isdStart), .bridgeCmd(bridgeCmd), .isdPlan(isdPlan),
    .speedInit(speedInit), .curInit(curInit), .isdDone(isdDone), .isdResult(isdResult),
    .motorSpeed(motorSpeed), .phaseCurrent(phaseCurrent), .startupDone(startupDone),
    .zeroCrossed(zeroCrossed));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  // hang guard, far above the several hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      final_report();
    end
  end
  task automatic tick(int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask : tick
  task automatic chk(logic [31:0] g, logic [31:0] e, string m);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk
  task automatic wait_st(mss_state_type s, int max);
    n = 0;
    while (stateOut !== s && n < max) begin
      tick(1);
      n++;
    end
    chk(stateOut, s, "state");
  endtask : wait_st
  task automatic pulse_dir;
    dirChangeCmd = 1'b1;
    tick(1);
    dirChangeCmd = 1'b0;
  endtask : pulse_dir
  task automatic base;
    cfg = '0;
    cfg.initialSpinDetectEnable = 1'b1;
    cfg.openClosedHandoffSpeed = 16'h0010;
    cfg.stationaryBemfThreshold = 16'h000A;
    cfg.forwardResyncSpeedThreshold = 16'h0064;
    cfg.revHandoffSpeed = 16'h000A;
    cfg.brakingCurrentThreshold = 16'h0014;
    cfg.brakingCurrentPersistTime = 16'h0005;
    isdPlan = '{16'h0032, 16'h0032, 16'h1234, 1'b0};
  endtask : base
  task automatic boot;
    nrst = 1'b0;
    cfgValid = 1'b0;
    speedRef = 16'h0;
    tick(3);
    chk(periphInit, 1, "periph");
    chk(bridgeCmd, MSS_BR_OFF, "bridge");
    nrst = 1'b1;
    tick(20);
    chk(nvmLoad, 1, "load");
    chk(ready, 0, "ready");
    cfgValid = 1'b1;
    wait_st(MSS_ST_IDLE, 4);
  endtask : boot
  task automatic t_idle_start;
    for (int m = 0; m < 4; m++) begin
      base;
      cfg.initialSpinDetectEnable = 1'b0;
      cfg.deviceOperatingSelect = 1'b1;
      cfg.standstillStartMethod = mss_start_type'(m);
      boot;
      wakePin = m[0];
      pulse_dir;
      tick(4);
      chk(sleepMode, !m[0], "sleep");
      chk(standbyMode, m[0], "standby");
      chk(speedTarget, 0, "target");
      chk(stateOut, MSS_ST_IDLE, "held");
      speedRef = 16'h0040;
      wait_st(MSS_ST_STARTUP, 6);
      chk(startMethod, m, "method");
      chk(speedTarget, 16'h0040, "target");
      wait_st(MSS_ST_CLOSED_LOOP, 40);
      chk(bridgeCmd, MSS_BR_CLOSED_LOOP, "bridge");
    end
  endtask : t_idle_start
  task automatic t_brake;
    for (int s = 0; s < 4; s++) begin
      base;
      cfg.brakeEnable = 1'b1;
      cfg.brakingTypeSelect = s[1];
      cfg.brakingSideSelect = s[0];
      cfg.brakingDuration = (s == 3) ? 16'h001E : (s == 2) ? 16'h00C8 : 16'h0014;
      curInit = (s == 3) ? 16'h03E8 : 16'h0032;
      isdPlan.bemf = 16'h0005;
      boot;
      speedRef = 16'h0040;
      wait_st(MSS_ST_BRAKE, 10);
      chk(bridgeCmd, (s == 1) ? MSS_BR_BRAKE_HIGH : MSS_BR_BRAKE_LOW, "side");
      wait_st(MSS_ST_STARTUP, 60);
      if (s == 3) chk(n >= 29 && n <= 34, 1, "timeout");
      else if (s == 2) chk(n >= 36 && n <= 40, 1, "settle");
      else chk(n >= 19 && n <= 24, 1, "brake time");
    end
  endtask : t_brake
  task automatic t_forward;
    for (int i = 0; i < 2; i++) begin
      base;
      cfg.resyncEnable = 1'b1;
      isdPlan.speed = i ? 16'h0032 : 16'h00C8;
      speedInit = isdPlan.speed;
      boot;
      speedRef = 16'h0040;
      wait_st(MSS_ST_RESYNC_SPEED, 10);
      wait_st(i ? MSS_ST_OPEN_LOOP : MSS_ST_CLOSED_LOOP, 3);
      if (!i) begin
        chk(seedValid, 1, "seed valid");
        chk({seedSpeed, seedAngle}, {16'h00C8, 16'h1234}, "seed");
        pulse_dir;
        wait_st(MSS_ST_ISD_CHECK, 3);
      end
    end
  endtask : t_forward
  task automatic t_coast;
    base;
    cfg.coastEnable = 1'b1;
    cfg.coastDuration = 16'h0019;
    cfg.brakeEnable = 1'b1;
    cfg.brakingDuration = 16'h000A;
    boot;
    speedRef = 16'h0040;
    wait_st(MSS_ST_COAST, 10);
    chk(bridgeCmd, MSS_BR_OFF, "coast");
    wait_st(MSS_ST_BRAKE_CHECK, 40);
    chk(n >= 24 && n <= 29, 1, "coast time");
    wait_st(MSS_ST_BRAKE, 3);
  endtask : t_coast
  task automatic t_reverse;
    for (int i = 0; i < 3; i++) begin
      base;
      cfg.counterRotationDriveEnable = (i != 2);
      cfg.counterRotationParamSelect = (i == 0);
      cfg.reversalPathSelect = 1'b1;
      cfg.openClosedHandoffSpeed = 16'h0028;
      isdPlan = '{16'h0032, 16'h001E, 16'h0000, 1'b1};
      speedInit = 16'h001E;
      boot;
      speedRef = 16'h0040;
      if (i == 2) begin
        wait_st(MSS_ST_STARTUP, 12);
      end else begin
        wait_st(MSS_ST_REV_CLOSED, 10);
        chk(useReverseParams, (i == 0), "params");
        wait_st(MSS_ST_REV_OPEN, 30);
        chk(i ? (n <= 2) : (n >= 18 && n <= 23), 1, "handoff");
        chk(bridgeCmd, MSS_BR_REV_OPEN, "bridge");
      end
      if (i == 0) begin
        wait_st(MSS_ST_CLOSED_LOOP, 40);
        pulse_dir;
        wait_st(MSS_ST_REV_CLOSED, 3);
      end
    end
  endtask : t_reverse
  initial begin
    t_idle_start;
    t_brake;
    t_forward;
    t_coast;
    t_reverse;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
